// [sim/mds_host_model.sv]
/*
  Host side: one-cycle reads of the register at addrIn, answer captured.
  Assumes doRead is raised for one cycle per read.
*/
`timescale 1ns/100ps
module mds_host_model
  import mds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic doRead,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire logic regRdValid,
  input wire logic [DATA_W-1:0] regRdata,
  output logic regRead,
  output logic [ADDR_W-1:0] regAddr,
  output logic [DATA_W-1:0] word,
  output logic done
);
  // Address turns over off the strobe so a late sample shows
  always @(posedge ref_clk)
  begin
    regRead <= doRead;
    regAddr <= doRead ? addrIn : ~addrIn;
    done <= regRdValid;
    if (regRdValid)
      word <= regRdata;
  end
endmodule // mds_host_model

// [sim/mds_status_flags_sva.sv]
/*
  Checker on the status word ports.
  Assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/100ps
module mds_status_flags_sva
  import mds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic stepPin,
  input wire logic quietChopperActive,
  input wire logic [CS_W-1:0] csActual,
  input wire logic overheatCmp,
  input wire logic [SHORT_N-1:0] shortDetect,
  input wire logic regRead,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regRdata,
  input wire logic regRdValid,
  input wire logic bridgeDisable,
  input wire logic standstill,
  input wire logic [CS_W-1:0] currentScale
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_valid_caused: assert property (regRdValid |-> $past(regRead))
    else $error("valid without read");
  a_reserved_zero: assert property (regRdValid |-> !regRdata[29:21] && !regRdata[15:12])
    else $error("reserved bits set");
  a_unmapped_zero: assert property (regRead && regAddr != DRIVER_STATUS_WORD_ADDR
    |=> regRdata == 32'h0) else $error("unmapped read not zero");
  a_mode_bit: assert property (regRead && regAddr == DRIVER_STATUS_WORD_ADDR && $past(rst_n)
    |=> regRdata[30] == $past(quietChopperActive, 2)) else $error("mode bit wrong");
  a_scale_copy: assert property ($past(rst_n) |-> currentScale == $past(csActual))
    else $error("scale copy wrong");
  a_short_disable: assert property ($rose(|shortDetect) |-> ##[1:5] bridgeDisable)
    else $error("short left bridges on");
  a_step_clears: assert property ($rose(stepPin) |-> ##[1:6] !standstill)
    else $error("step kept standstill");
  a_overheat_off: assert property ($rose(overheatCmp) |-> ##[1:5] bridgeDisable)
    else $error("overheat left bridges on");
endmodule // mds_status_flags_sva

bind mds_status_flags mds_status_flags_sva mds_status_flags_sva_i (.*);

// [sim/mds_status_flags_test.sv]
/*
  Bench for the status word, read through the host model.
  Assumes a standstill count shortened to 16.
*/
`timescale 1ns/100ps
module mds_status_flags_test
  import mds_pkg::*;
;
  logic ref_clk = 0, rst_n = 0, stepPin = 0, driverEnablePin_n = 0, quietChopperActive = 0;
  logic overheatCmp = 0, preWarnCmp = 0, openLoadB = 0, openLoadA = 0, regWrite = 0, doRead = 0;
  logic [3:0] chopperOffTime = 4'h3, tempCmp = 4'h0, shortDetect = 4'h0;
  logic [4:0] csActual = 5'h0;
  logic [6:0] addrIn = 7'h0;
  logic [31:0] regWdata = 32'h0;
  logic regRead, regRdValid, bridgeDisable, standstill, done;
  logic [6:0] regAddr;
  logic [31:0] regRdata, word;
  logic [4:0] currentScale;
  int badCount = 0, totalChecks = 0;
  always #2.5 ref_clk = ~ref_clk;
  mds_status_flags #(.STANDSTILL_CYCLES(16)) mds_status_flags_i (.*);
  mds_host_model mds_host_model_i (.*);
  task automatic conclude();
    $display("checks %0d bad %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e)
    begin
      badCount++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [6:0] a);
    int n = 0;
    doRead = 1;
    addrIn = a;
    w(1);
    doRead = 0;
    while (done !== 1'b1 && n < 8)
    begin
      w(1);
      n++;
    end
    if (done !== 1'b1)
    begin
      badCount++;
      conclude();
    end
  endtask
  // Built from live inputs, so sources must have settled before the read
  function automatic logic [31:0] ew(input logic [3:0] sh, input logic [1:0] op);
    return {1'b1, quietChopperActive, 9'h0, csActual, 4'h0, tempCmp, openLoadB, openLoadA, sh, op};
  endfunction
  task automatic rw(input string n, input logic [31:0] e);
    rd(DRIVER_STATUS_WORD_ADDR);
    chk(n, e, word);
  endtask
  task automatic cb(input string n, input logic e);
    chk(n, {31'h0, e}, {31'h0, bridgeDisable});
  endtask
  initial
  begin
    w(4);
    rst_n = 1;
    w(20);
    for (int i = 0; i < 2; i++)
    begin
      quietChopperActive = i[0];
      csActual = i ? CS_FULL_SCALE : 5'h0a;
      tempCmp = i ? 4'ha : 4'h5;
      {openLoadB, openLoadA} = i ? 2'b10 : 2'b01;
      w(4);
      rw("fields", ew(4'h0, 2'b00));
      chk("scale", {27'h0, csActual}, {27'h0, currentScale});
      cb("olnoact", 0);
    end
    regWrite = 1;
    regWdata = '1;
    rw("write", ew(4'h0, 2'b00));
    regWrite = 0;
    rd(7'h6e);
    chk("unmapped", 32'h0, word);
    stepPin = 1;
    w(3);
    stepPin = 0;
    w(2);
    rw("moving", ew(4'h0, 2'b00) ^ 32'h8000_0000);
    chk("ststmove", 32'h0, {31'h0, standstill});
    w(20);
    rw("still", ew(4'h0, 2'b00));
    chk("ststidle", 32'h1, {31'h0, standstill});
    $display("t1 end");
    for (int i = 0; i < 4; i++)
    begin
      shortDetect = 4'h1 << i;
      w(4);
      shortDetect = 0;
      w(4);
      rw("short", ew(4'h1 << i, 2'b00));
      quietChopperActive = 0;
      w(3);
      rw("othermode", ew(4'h0, 2'b00));
      cb("bridgeoff", 1);
      quietChopperActive = 1;
      w(3);
      rw("backmode", ew(4'h1 << i, 2'b00));
      if (i[0])
        driverEnablePin_n = 1;
      else
        chopperOffTime = OFFTIME_DRIVER_OFF;
      w(4);
      {driverEnablePin_n, chopperOffTime} = 5'h03;
      w(4);
      rw("cleared", ew(4'h0, 2'b00));
      cb("bridgeon", 0);
    end
    $display("t2 end");
    {preWarnCmp, overheatCmp} = 2'b11;
    w(4);
    rw("hot", ew(4'h0, 2'b11));
    overheatCmp = 0;
    w(4);
    rw("warm", ew(4'h0, 2'b11));
    cb("warmoff", 1);
    preWarnCmp = 0;
    w(4);
    rw("cool", ew(4'h0, 2'b00));
    cb("coolon", 0);
    $display("t3 end");
    conclude();
  end
endmodule // mds_status_flags_test

// [verilog/mds_pkg.sv]
/*
  Constants for the driver status word: address, field positions and widths.
  Assumes the serial configuration engine presents an address of ADDR_W bits.
*/
package mds_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam int CS_W = 5;
  localparam int OFFTIME_W = 4;
  localparam logic [ADDR_W-1:0] DRIVER_STATUS_WORD_ADDR = 7'h6f;
  localparam logic [OFFTIME_W-1:0] OFFTIME_DRIVER_OFF = 4'h0;
  localparam logic [CS_W-1:0] CS_FULL_SCALE = 5'h1f;
  localparam logic [DATA_W-1:0] STATUS_RESET = 32'h0000_0000;
  localparam int STANDSTILL_CYCLES_DEF = 1048576;
  localparam int BIT_STANDSTILL = 31;
  localparam int BIT_QUIET_MODE = 30;
  localparam int BIT_CS_HI = 20;
  localparam int BIT_CS_LO = 16;
  localparam int BIT_TEMP_HI = 11;
  localparam int BIT_TEMP_LO = 8;
  localparam int BIT_OPEN_B = 7;
  localparam int BIT_OPEN_A = 6;
  localparam int BIT_SHORT_HI = 5;
  localparam int BIT_SHORT_LO = 2;
  localparam int BIT_OVERHEAT = 1;
  localparam int BIT_PREWARN = 0;
  localparam int TEMP_N = 4;
  localparam int SHORT_N = 4;
  localparam int MODE_N = 2;
  localparam int MODE_CYCLE = 0;
  localparam int MODE_QUIET = 1;
endpackage

// [verilog/mds_status_flags.sv]
/*
  Driver status word: standstill timer, chopper mode, current scale, temperature
  comparators, open-load and short diagnostics, overtemperature latch and bridge disable.
  Assumes a serial configuration engine on ref_clk issues single-cycle read/write strobes,
  and that analog comparators and pins arrive asynchronously.
*/
//
// Behaviour
// [R1] Standstill bit sets 2^20 clocks after last step pulse; clears on stepping.
// [R2] Bit 30 set for quiet voltage chopper, clear for cycle-based chopper.
// [R3] Bits 20..16 show current scale presently applied by current control.
// [R4] Current scale 31 means full current; lower values scale proportionally.
// [R5] Bits 11..8 show 157/150/143/120 degree comparators while exceeded.
// [R6] Bit 7 open load phase B, bit 6 open load phase A.
// [R7] Open-load flags trigger no protection; host checks them during slow motion.
// [R8] Low-side short sets bit 5 (B) or 4 (A) and disables bridges.
// [R9] Short to ground sets bit 3 (B) or 2 (A) and disables bridges.
// [R10] Short flags hold until off-time zero or enable pin deasserted.
// [R11] Separate short flag sets per chopper mode; active mode's set reported.
// [R12] Bit 1 on overheat; bridges stay off until pre-warning also clears.
// [R13] Bit 0 follows pre-warning threshold, clearing when temperature falls below.
// [R14] One overheat and one pre-warning flag shared by both bridges.
// [R15] Reserved bits read zero; host ignores them.
// [R16] Status word read-only; reads change nothing, writes ignored.
`timescale 1ns/100ps
module mds_status_flags
  import mds_pkg::*;
#(
  parameter int STANDSTILL_CYCLES = STANDSTILL_CYCLES_DEF,
  parameter int CNT_W = 21
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic stepPin,
  input wire logic driverEnablePin_n,
  input wire logic [OFFTIME_W-1:0] chopperOffTime,
  input wire logic quietChopperActive,
  input wire logic [CS_W-1:0] csActual,
  input wire logic [TEMP_N-1:0] tempCmp,
  input wire logic overheatCmp,
  input wire logic preWarnCmp,
  input wire logic openLoadB,
  input wire logic openLoadA,
  input wire logic [SHORT_N-1:0] shortDetect,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  output logic [DATA_W-1:0] regRdata,
  output logic regRdValid,
  output logic bridgeDisable,
  output logic standstill,
  output logic [CS_W-1:0] currentScale
);
  localparam int SYNC_W = 2 + TEMP_N + 2 + SHORT_N;
  localparam logic [CNT_W-1:0] STANDSTILL_LAST = CNT_W'(STANDSTILL_CYCLES - 1);

  typedef struct packed {
    logic stepPrev;
    logic [CNT_W-1:0] idleCount;
    logic standstill;
    logic [MODE_N-1:0][SHORT_N-1:0] shortFlags;
    logic overheatLatch;
    logic bridgeDisable;
    logic [DATA_W-1:0] statusWord;
    logic [DATA_W-1:0] rdata;
    logic rdValid;
    logic [CS_W-1:0] currentScale;
  } mds_state_t;

  mds_state_t state_reg;
  mds_state_t state_next;

  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] syncOut;
  logic stepSync;
  logic enableNSync;
  logic [TEMP_N-1:0] tempSync;
  logic overheatSync;
  logic preWarnSync;
  logic [SHORT_N-1:0] shortSync;
  logic driverOff;
  logic stepEdge;
  logic activeMode;
  logic anyShort;

  // Pins and analog comparators are asynchronous to ref_clk
  assign syncIn = {stepPin, driverEnablePin_n, tempCmp, overheatCmp, preWarnCmp, shortDetect};

  mds_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn(syncIn),
    .syncOut(syncOut)
  );

  assign {stepSync, enableNSync, tempSync, overheatSync, preWarnSync, shortSync} = syncOut;

  assign stepEdge = stepSync && !state_reg.stepPrev;
  assign driverOff = (chopperOffTime == OFFTIME_DRIVER_OFF) || enableNSync;
  assign activeMode = quietChopperActive;

  always_comb
  begin
    state_next = state_reg;
    anyShort = 1'b0;

    // Standstill timer saturates so the flag stays up during long pauses
    state_next.stepPrev = stepSync;
    if (stepEdge)
    begin
      state_next.idleCount = '0; // [R1]
      state_next.standstill = 1'b0; // [R1]
    end
    else if (state_reg.idleCount != STANDSTILL_LAST)
    begin
      state_next.idleCount = state_reg.idleCount + CNT_W'(1);
    end
    else
    begin
      state_next.standstill = 1'b1; // [R1]
    end

    // Each chopper keeps its own short flags; switching mode does not lose the other set
    for (int m = 0; m < MODE_N; m++)
    begin
      for (int s = 0; s < SHORT_N; s++)
      begin
        if (shortSync[s] && (activeMode == m[0]))
          state_next.shortFlags[m][s] = 1'b1; // [R8] [R9] [R11]
        else if (driverOff)
          state_next.shortFlags[m][s] = 1'b0; // [R10]
      end
    end

    // Any latched short of either mode keeps the bridges off until the driver is switched off
    for (int m = 0; m < MODE_N; m++)
    begin
      anyShort = anyShort || (|state_next.shortFlags[m]);
    end

    // Overheat releases only once the shared pre-warning has dropped as well
    if (overheatSync)
      state_next.overheatLatch = 1'b1; // [R12] [R14]
    else if (!preWarnSync)
      state_next.overheatLatch = 1'b0; // [R12]

    // Open-load flags do not feed the disable term
    state_next.bridgeDisable = anyShort || state_next.overheatLatch; // [R7] [R8] [R9] [R12]

    state_next.statusWord = STATUS_RESET; // [R15]
    state_next.statusWord[BIT_STANDSTILL] = state_reg.standstill; // [R1]
    state_next.statusWord[BIT_QUIET_MODE] = quietChopperActive; // [R2]
    state_next.statusWord[BIT_CS_HI:BIT_CS_LO] = csActual; // [R3]
    state_next.statusWord[BIT_TEMP_HI:BIT_TEMP_LO] = tempSync; // [R5]
    state_next.statusWord[BIT_OPEN_B] = openLoadB; // [R6]
    state_next.statusWord[BIT_OPEN_A] = openLoadA; // [R6]
    state_next.statusWord[BIT_SHORT_HI:BIT_SHORT_LO] = state_reg.shortFlags[activeMode]; // [R11]
    state_next.statusWord[BIT_OVERHEAT] = state_reg.overheatLatch; // [R12] [R14]
    state_next.statusWord[BIT_PREWARN] = preWarnSync; // [R13] [R14]

    // Current scale passed on to the bridge drive; CS_FULL_SCALE is full current
    state_next.currentScale = csActual; // [R4]

    // Reads return a snapshot and touch no flag; writes have no target here
    state_next.rdValid = regRead; // [R16]
    if (regRead && (regAddr == DRIVER_STATUS_WORD_ADDR))
      state_next.rdata = state_reg.statusWord; // [R16]
    else if (regRead)
      state_next.rdata = STATUS_RESET;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign regRdata = state_reg.rdata;
  assign regRdValid = state_reg.rdValid;
  assign bridgeDisable = state_reg.bridgeDisable;
  assign standstill = state_reg.standstill;
  assign currentScale = state_reg.currentScale;

  // Write strobe and data are accepted and dropped: the word has no writable field
  logic unusedWrite;
  assign unusedWrite = regWrite ^ (^regWdata);
endmodule // mds_status_flags

// [verilog/mds_sync.sv]
/*
  Two-flop synchroniser for a group of asynchronous level inputs.
  Assumes every input bit is a slow level; pulses shorter than one clock may be lost.
*/
`timescale 1ns/100ps
module mds_sync
  import mds_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } mds_sync_state_t;

  mds_sync_state_t state_reg;
  mds_sync_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < WIDTH; i++)
    begin
      state_next.stage1[i] = asyncIn[i];
      state_next.stage2[i] = state_reg.stage1[i];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign syncOut = state_reg.stage2;
endmodule // mds_sync
